// *** pdbt_map.vh ***
// Register offsets, field positions, reset values and timing counts for the PD self-test block
`ifndef PDBT_MAP_VH
`define PDBT_MAP_VH

`define PDBT_ADDR_W           16
`define PDBT_OFF_CTL_FIRST    16'h1ac0
`define PDBT_OFF_CTL_SECOND   16'h1ac1
`define PDBT_OFF_ERR_UPPER    16'h1ac2
`define PDBT_OFF_ERR_LOWER    16'h1ac3
`define PDBT_OFF_RX_STATUS    16'h1ac7

`define PDBT_CTLA_RX_EN       4
`define PDBT_CTLA_MASTER_EN   3
`define PDBT_CTLA_MODE_HI     2
`define PDBT_CTLA_MODE_LO     0
`define PDBT_CTLA_RESET       8'h00
`define PDBT_MODE_CARRIER     3'h2

`define PDBT_CTLB_CLR_CNT     2
`define PDBT_CTLB_TX_RST      1
`define PDBT_CTLB_TX_START    0

`define PDBT_STAT_RX_ERROR    1
`define PDBT_STAT_RX_DONE     0

`define PDBT_ERR_CNT_RESET    16'h0000
`define PDBT_ERR_CNT_MAX      16'hffff

`define PDBT_CLK_HZ           20000000
`define PDBT_BIT_RATE_HZ      300000
`define PDBT_BIT_DIV          (`PDBT_CLK_HZ / `PDBT_BIT_RATE_HZ)
`define PDBT_FRAME_BITS       1056
`define PDBT_PRBS_SEED        16'hffff

`endif

// *** pdbt_fifo.v ***
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module pdbt_fifo #(
	parameter WIDTH = 1,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// Clock and reset
	input  wire             sys_clk,
	input  wire             reset_n,
	input  wire             flush,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	wire            push;
	wire            pop;

	assign in_ready  = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data  = mem_reg[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always @(posedge sys_clk) begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule // pdbt_fifo

// *** pdbt_self_test.v ***
// PD MAC self-test transmit, receive-check and error-count control
// Functional notes
// - Writing one to clear-count bit 2 zeroes both error count bytes.
// - Writing one to transmit-reset bit 1 resets transmit logic and pattern generator.
// - Transmit-reset is a strobe and always reads zero.
// - Transmit-reset stops continuous sending within one bit time.
// - Reset and start written together: reset acts, start is discarded.
// - Writing one to bit 0 launches a test frame.
// - Reading bit 0 returns whether transmission is in progress.
// - Carrier mode runs until reset; other modes end after one frame.
// - No automatic next frame; software clears then sets start again.
// - Receive mode with auto response and loopback off sends the error-count message at frame end.
// - Error count reads as upper then lower read-only byte, zero at reset.
// - Receive-error bit is one if the error count is nonzero at frame end.
// - Receive-done sets at frame end; writing one clears it.
// - Loopback with receive enabled checks each transmitted frame internally.
// - Setting receive-enable re-seeds the checker and zeroes the error counter.
// - Master enable powers the line transmitter; software waits 5us before start.
// - Carrier mode 010b sends alternating ones and zeros; every other mode sends the PRBS pattern.
`timescale 1ns/1ps
`include "pdbt_map.vh"
module pdbt_self_test #(
	parameter BIT_DIV    = `PDBT_BIT_DIV,
	parameter FRAME_BITS = `PDBT_FRAME_BITS,
	parameter FIFO_DEPTH = 16
) (
	// Clock and reset
	input  wire                   sys_clk,
	input  wire                   reset_n,
	// Register port
	input  wire [`PDBT_ADDR_W-1:0] reg_addr,
	input  wire                   reg_wr,
	input  wire                   reg_rd,
	input  wire [7:0]             reg_wdata,
	output reg  [7:0]             reg_rdata,
	// Options held elsewhere in the MAC
	input  wire                   loopback_enable,
	input  wire                   automatic_response_enable,
	// Line side
	output reg                    tx_bit,
	output reg                    tx_bit_valid,
	output reg                    bmc_tx_power,
	input  wire                   rx_bit,
	input  wire                   rx_bit_valid,
	input  wire                   rx_frame_end,
	// Error-count message request to the MAC
	output reg                    err_msg_request,
	output reg  [15:0]            err_msg_count
);
	reg [7:0]  ctl_first_reg;
	reg        tx_active_reg;
	reg        tx_armed_reg;
	reg [15:0] prbs_reg;
	reg        carrier_reg;
	reg [15:0] div_reg;
	reg [15:0] tx_bits_reg;
	reg [15:0] chk_reg;
	reg [15:0] err_cnt_reg;
	reg        rx_done_reg;
	reg        rx_error_reg;
	reg        rx_en_d_reg;
	reg        rx_gate_reg;
	reg        fifo_ok_reg;

	wire       rx_en      = ctl_first_reg[`PDBT_CTLA_RX_EN];
	wire       master_en  = ctl_first_reg[`PDBT_CTLA_MASTER_EN];
	wire [2:0] mode       = ctl_first_reg[`PDBT_CTLA_MODE_HI:`PDBT_CTLA_MODE_LO];
	wire       wr_second  = reg_wr && reg_addr == `PDBT_OFF_CTL_SECOND;
	wire       tx_rst     = wr_second && reg_wdata[`PDBT_CTLB_TX_RST];
	wire       tx_start   = wr_second && reg_wdata[`PDBT_CTLB_TX_START] && !tx_rst;
	wire       clr_cnt    = wr_second && reg_wdata[`PDBT_CTLB_CLR_CNT];
	wire       rx_en_rise = rx_en && !rx_en_d_reg;
	wire       bit_tick   = (div_reg == BIT_DIV[15:0] - 16'h0001);
	wire       prbs_bit   = prbs_reg[15];
	wire       is_carrier = (mode == `PDBT_MODE_CARRIER);

	// Looped-back bits pass the FIFO before reaching the checker
	wire       loop_mode  = loopback_enable && rx_en;
	wire       fifo_in_rdy;
	wire       fifo_out_vld;
	wire       fifo_out_bit;
	wire       src_valid  = loop_mode ? (tx_active_reg && bit_tick) : rx_bit_valid;
	wire       src_bit    = loop_mode ? (is_carrier ? carrier_reg : prbs_bit) : rx_bit;
	wire       chk_take   = fifo_out_vld && rx_gate_reg;

	function [15:0] prbs_step;
		input [15:0] s;
		begin
			prbs_step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
		end
	endfunction

	pdbt_fifo #(
		.WIDTH (1),
		.DEPTH (FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.flush     (rx_en_rise),
		.in_valid  (src_valid && rx_en),
		.in_ready  (fifo_in_rdy),
		.in_data   (src_bit),
		.out_valid (fifo_out_vld),
		.out_ready (rx_gate_reg),
		.out_data  (fifo_out_bit)
	);

	// Control register and transmit side
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctl_first_reg <= `PDBT_CTLA_RESET;
			tx_active_reg <= 1'b0;
			tx_armed_reg  <= 1'b1;
			prbs_reg      <= `PDBT_PRBS_SEED;
			carrier_reg   <= 1'b0;
			div_reg       <= 16'h0000;
			tx_bits_reg   <= 16'h0000;
			tx_bit        <= 1'b0;
			tx_bit_valid  <= 1'b0;
			bmc_tx_power  <= 1'b0;
		end else begin
			bmc_tx_power <= master_en;
			if (reg_wr && reg_addr == `PDBT_OFF_CTL_FIRST)
				ctl_first_reg <= {3'h0, reg_wdata[4:0]};
			if (wr_second && !reg_wdata[`PDBT_CTLB_TX_START])
				tx_armed_reg <= 1'b1;
			if (tx_rst) begin
				tx_active_reg <= 1'b0;
				prbs_reg      <= `PDBT_PRBS_SEED;
				carrier_reg   <= 1'b0;
				div_reg       <= 16'h0000;
				tx_bits_reg   <= 16'h0000;
				tx_bit_valid  <= 1'b0;
			end else if (tx_start && tx_armed_reg && !tx_active_reg) begin
				tx_active_reg <= 1'b1;
				tx_armed_reg  <= 1'b0;
				div_reg       <= 16'h0000;
				tx_bits_reg   <= 16'h0000;
			end else if (tx_active_reg) begin
				div_reg      <= bit_tick ? 16'h0000 : div_reg + 16'h0001;
				tx_bit_valid <= bit_tick;
				if (bit_tick) begin
					if (is_carrier) begin
						tx_bit      <= carrier_reg;
						carrier_reg <= ~carrier_reg;
					end else begin
						tx_bit   <= prbs_bit;
						prbs_reg <= prbs_step(prbs_reg);
					end
					tx_bits_reg <= tx_bits_reg + 16'h0001;
					if (!is_carrier && tx_bits_reg == FRAME_BITS[15:0] - 16'h0001)
						tx_active_reg <= 1'b0;
				end
			end else begin
				tx_bit_valid <= 1'b0;
			end
		end
	end

	// Receive checker, error counter and status
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			chk_reg         <= `PDBT_PRBS_SEED;
			err_cnt_reg     <= `PDBT_ERR_CNT_RESET;
			rx_done_reg     <= 1'b0;
			rx_error_reg    <= 1'b0;
			rx_en_d_reg     <= 1'b0;
			rx_gate_reg     <= 1'b0;
			fifo_ok_reg     <= 1'b0;
			err_msg_request <= 1'b0;
			err_msg_count   <= 16'h0000;
		end else begin
			rx_en_d_reg     <= rx_en;
			rx_gate_reg     <= rx_en;
			fifo_ok_reg     <= fifo_in_rdy;
			err_msg_request <= 1'b0;
			if (rx_en_rise) begin
				chk_reg     <= `PDBT_PRBS_SEED;
				err_cnt_reg <= `PDBT_ERR_CNT_RESET;
			end else begin
				if (chk_take) begin
					chk_reg <= prbs_step(chk_reg);
					if (fifo_out_bit != chk_reg[15] && err_cnt_reg != `PDBT_ERR_CNT_MAX)
						err_cnt_reg <= err_cnt_reg + 16'h0001;
				end
				if (clr_cnt)
					err_cnt_reg <= `PDBT_ERR_CNT_RESET;
			end
			// Frame end: set wins over a same-cycle write-one clear
			if (rx_en && rx_frame_end) begin
				rx_done_reg  <= 1'b1;
				rx_error_reg <= (err_cnt_reg != `PDBT_ERR_CNT_RESET);
				if (automatic_response_enable && !loopback_enable) begin
					err_msg_request <= 1'b1;
					err_msg_count   <= err_cnt_reg;
				end
			end else if (reg_wr && reg_addr == `PDBT_OFF_RX_STATUS
				&& reg_wdata[`PDBT_STAT_RX_DONE]) begin
				rx_done_reg <= 1'b0;
			end
		end
	end

	// Register read port
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`PDBT_OFF_CTL_FIRST:  reg_rdata <= ctl_first_reg;
			`PDBT_OFF_CTL_SECOND: reg_rdata <= {7'h00, tx_active_reg};
			`PDBT_OFF_ERR_UPPER:  reg_rdata <= err_cnt_reg[15:8];
			`PDBT_OFF_ERR_LOWER:  reg_rdata <= err_cnt_reg[7:0];
			`PDBT_OFF_RX_STATUS:  reg_rdata <= {6'h00, rx_error_reg, rx_done_reg};
			default:              reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule // pdbt_self_test

// *** pdbt_self_test_properties.sv ***
// Port-level assertions for the PD self-test block
`timescale 1ns/1ps
module pdbt_self_test_properties (
	// Clock and reset
	input wire        sys_clk,
	input wire        reset_n,
	// Register port
	input wire [15:0] reg_addr,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [7:0]  reg_wdata,
	input wire [7:0]  reg_rdata,
	// Options and line
	input wire        loopback_enable,
	input wire        automatic_response_enable,
	input wire        tx_bit_valid,
	input wire        bmc_tx_power,
	input wire        rx_frame_end,
	input wire        err_msg_request
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	wire ctl_wr = reg_wr && reg_addr == 16'h1ac1;
	wire st_rd  = reg_rd && reg_addr == 16'h1ac7;

	strobe_reads_zero_a: assert property (reg_rd && reg_addr == 16'h1ac1 |=> reg_rdata[7:1] == 7'h00)
		else $error("write-only bit read back set");
	power_follows_a: assert property (reg_wr && reg_addr == 16'h1ac0 |-> ##2 bmc_tx_power == $past(reg_wdata[3], 2))
		else $error("line power not following master enable");
	tx_stops_a: assert property (ctl_wr && reg_wdata[1] |=> !tx_bit_valid [*8])
		else $error("sending went on after pattern reset");
	bit_spacing_a: assert property (tx_bit_valid |=> !tx_bit_valid [*3])
		else $error("bits closer than one bit time");
	msg_pulse_a: assert property (err_msg_request |=> !err_msg_request)
		else $error("message request longer than one cycle");
	msg_cause_a: assert property (err_msg_request |-> $past(rx_frame_end) && $past(automatic_response_enable) && !$past(loopback_enable))
		else $error("message request without its cause");
	done_clear_a: assert property (reg_wr && reg_addr == 16'h1ac7 && reg_wdata[0] && !rx_frame_end ##1 !rx_frame_end ##1 st_rd |=> !reg_rdata[0])
		else $error("done flag not cleared");
	status_spare_a: assert property (st_rd |=> reg_rdata[7:2] == 6'h00)
		else $error("spare status bits set");
endmodule // pdbt_self_test_properties

bind pdbt_self_test pdbt_self_test_properties u_props (.sys_clk(sys_clk), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .loopback_enable(loopback_enable),
	.automatic_response_enable(automatic_response_enable), .tx_bit_valid(tx_bit_valid),
	.bmc_tx_power(bmc_tx_power), .rx_frame_end(rx_frame_end), .err_msg_request(err_msg_request));

// *** pdbt_line_model.sv ***
// Far-port model: echoes sent bits, flips the first few of a frame, then ends the frame
`timescale 1ns/1ps
module pdbt_line_model #(
	parameter FRAME_BITS = 16
) (
	// Clock and reset
	input wire       sys_clk,
	input wire       reset_n,
	// From the block
	input wire       tx_bit,
	input wire       tx_bit_valid,
	// From the bench
	input wire [7:0] corrupt_n,
	// Back to the block
	output reg       rx_bit,
	output reg       rx_bit_valid,
	output reg       rx_frame_end
);
	integer seen_reg;
	integer tail_reg;
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			seen_reg <= 0;
			tail_reg <= 0;
			rx_bit <= 1'b0;
			rx_bit_valid <= 1'b0;
			rx_frame_end <= 1'b0;
		end else begin
			rx_bit_valid <= tx_bit_valid;
			// Idle line toggles so a stale bit is never mistaken for data
			rx_bit <= tx_bit_valid ? tx_bit ^ (seen_reg < corrupt_n) : ~rx_bit;
			rx_frame_end <= tail_reg == 1;
			if (tail_reg != 0)
				tail_reg <= tail_reg - 1;
			if (tx_bit_valid) begin
				seen_reg <= (seen_reg == FRAME_BITS - 1) ? 0 : seen_reg + 1;
				if (seen_reg == FRAME_BITS - 1)
					tail_reg <= 6;
			end
		end
	end
endmodule // pdbt_line_model

// *** pdbt_self_test_tb_top.sv ***
// Self-checking bench for the PD self-test block
`timescale 1ns/1ps
module pdbt_self_test_tb_top;
	reg         sys_clk = 1'b0;
	reg         reset_n = 1'b0;
	reg  [15:0] reg_addr = 16'h0000;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg  [7:0]  reg_wdata = 8'h00;
	reg         loop_en = 1'b0;
	reg         auto_en = 1'b0;
	reg  [7:0]  corrupt_n = 8'h00;
	wire [7:0]  reg_rdata;
	wire        tx_bit, tx_bit_valid, bmc_tx_power, rx_bit, rx_bit_valid, rx_frame_end;
	wire        err_msg_request;
	wire [15:0] err_msg_count;
	reg  [15:0] msg_seen = 16'h0000;
	reg  [7:0]  rd_val;
	reg         prev;
	integer     failures = 0;
	integer     n_checks = 0;
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (err_msg_request) msg_seen <= err_msg_count;
	pdbt_self_test #(.BIT_DIV(4), .FRAME_BITS(16)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .loopback_enable(loop_en), .automatic_response_enable(auto_en),
		.tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .bmc_tx_power(bmc_tx_power),
		.rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_frame_end(rx_frame_end),
		.err_msg_request(err_msg_request), .err_msg_count(err_msg_count));
	pdbt_line_model #(.FRAME_BITS(16)) u_far (.sys_clk(sys_clk), .reset_n(reset_n),
		.tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .corrupt_n(corrupt_n),
		.rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_frame_end(rx_frame_end));
	task chk(input string what, input [15:0] exp, input [15:0] got);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("unexpected %0s: expected %h, seen %h", what, exp, got);
			end
		end
	endtask
	task wr(input [15:0] a, input [7:0] d);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge sys_clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [15:0] a);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge sys_clk);
			reg_rd <= 1'b0;
			@(negedge sys_clk);
			rd_val = reg_rdata;
		end
	endtask
	task rdc(input [15:0] a, input [7:0] e);
		begin
			rd(a);
			chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rd_val});
		end
	endtask
	task wait_done;
		integer k;
		begin
			k = 0;
			rd_val = 8'h00;
			while (rd_val[0] !== 1'b1 && k < 60) begin
				rd(16'h1ac7);
				k = k + 1;
			end
		end
	endtask
	task wait_bit;
		integer k;
		begin
			k = 0;
			@(negedge sys_clk);
			while (tx_bit_valid !== 1'b1 && k < 20) begin
				@(negedge sys_clk);
				k = k + 1;
			end
		end
	endtask
	task t_reset;
		begin
			rdc(16'h1ac1, 8'h00);
			rdc(16'h1ac2, 8'h00);
			rdc(16'h1ac3, 8'h00);
			rdc(16'h1ac7, 8'h00);
			rdc(16'h1ac4, 8'h00);
			$display("t_reset ended");
		end
	endtask
	task t_loop;
		begin
			loop_en <= 1'b1;
			wr(16'h1ac0, 8'h18);
			repeat (100) @(posedge sys_clk);
			chk("line power", 16'h0001, {15'h0000, bmc_tx_power});
			wr(16'h1ac1, 8'h02);
			repeat (80) @(posedge sys_clk);
			wr(16'h1ac1, 8'h01);
			rdc(16'h1ac1, 8'h01);
			wait_done;
			rdc(16'h1ac7, 8'h01);
			rdc(16'h1ac3, 8'h00);
			rdc(16'h1ac1, 8'h00);
			wr(16'h1ac1, 8'h01);
			rdc(16'h1ac1, 8'h00);
			wr(16'h1ac7, 8'h01);
			rdc(16'h1ac7, 8'h00);
			$display("t_loop ended");
		end
	endtask
	task t_err;
		begin
			loop_en <= 1'b0;
			auto_en <= 1'b1;
			corrupt_n <= 8'h03;
			wr(16'h1ac0, 8'h08);
			wr(16'h1ac0, 8'h18);
			wr(16'h1ac1, 8'h02);
			repeat (80) @(posedge sys_clk);
			wr(16'h1ac1, 8'h00);
			wr(16'h1ac1, 8'h01);
			wait_done;
			rdc(16'h1ac7, 8'h03);
			rdc(16'h1ac2, 8'h00);
			rdc(16'h1ac3, 8'h03);
			chk("message count", 16'h0003, msg_seen);
			wr(16'h1ac1, 8'h04);
			rdc(16'h1ac3, 8'h00);
			$display("t_err ended");
		end
	endtask
	task t_carrier;
		begin
			auto_en <= 1'b0;
			corrupt_n <= 8'h00;
			wr(16'h1ac0, 8'h0a);
			wr(16'h1ac1, 8'h02);
			repeat (80) @(posedge sys_clk);
			wr(16'h1ac1, 8'h01);
			wait_bit;
			prev = tx_bit;
			repeat (40) begin
				wait_bit;
				chk("carrier bit", {15'h0000, ~prev}, {15'h0000, tx_bit});
				prev = tx_bit;
			end
			rdc(16'h1ac1, 8'h01);
			wr(16'h1ac1, 8'h02);
			repeat (8) @(posedge sys_clk);
			rdc(16'h1ac1, 8'h00);
			wr(16'h1ac1, 8'h03);
			rdc(16'h1ac1, 8'h00);
			$display("t_carrier ended");
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d, mismatches %0d", n_checks, failures);
			if (failures == 0 && n_checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_reset;
		t_loop;
		t_err;
		t_carrier;
		give_verdict;
	end
	initial begin
		#(4000 * 50);
		failures = failures + 1;
		give_verdict;
	end
endmodule // pdbt_self_test_tb_top
